// ### logic/boot_clock_setup_loader.sv
// Start-up sequencer: reset hold, PLL strap setup, boot source choice and image loader.
`timescale 1ns/10ps
`default_nettype none
// Function
// - While reset is low, stay in reset with all general-purpose pins undriven.
// - After release, count 750,000 clocks, then enable pin pulls and start booting.
// - Frequency straps pick reset output divider and multiplier; input divider resets to zero.
// - Tile clock is oscillator times (mul+1)/2 over (idiv+1) over (odiv+1).
// - Software may overwrite the three PLL fields through a writable register.
// - Clock-source strap low picks external resonator, high picks internal oscillator.
// - Normally the two upper mode strap bits choose the boot source.
// - Security bit 5 forces boot from one-time-programmable memory.
// - Image is size word, then size times four bytes, then check word.
// - Check word 0x0D15AB1E skips CRC verification.
// - Size and check words arrive least significant byte first.
// - Program bytes fill RAM from address zero; execution starts at zero.
// - CRC covers the size word bytes and all program bytes only.
// - Reflected CRC 0xEDB88320, preset all ones, result inverted.
// - Serial flash bytes arrive least significant bit first.
// - Flash boot issues a read at 24-bit address zero, mode 0.
module boot_clock_setup_loader
    import boot_loader_pkg::*;
#(
    parameter int unsigned HOLD_CLOCKS = RESET_HOLD_CLOCKS,
    parameter logic [1:0]  SRC_CODE_00 = 2'h0,
    parameter logic [1:0]  SRC_CODE_01 = 2'h1,
    parameter logic [1:0]  SRC_CODE_10 = 2'h3,
    parameter logic [1:0]  SRC_CODE_11 = 2'h3
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rstn,
    // Straps from pins
    input  wire logic                  clock_source_strap,
    input  wire logic                  freq_strap_0,
    input  wire logic                  freq_strap_1,
    input  wire logic [1:0]            boot_mode_strap,
    input  wire logic [31:0]           security_word,
    // Software PLL write
    input  wire logic                  pll_cfg_write,
    input  wire logic [2:0]            pll_cfg_output_divider,
    input  wire logic [11:0]           pll_cfg_multiplier,
    input  wire logic [5:0]            pll_cfg_input_divider,
    // Image byte stream from the boot source
    input  wire logic                  image_valid,
    input  wire logic [7:0]            image_byte,
    // Clock selection and PLL settings
    output logic                       use_internal_osc,
    output logic [2:0]                 pll_output_divider,
    output logic [11:0]                pll_multiplier,
    output logic [5:0]                 pll_input_divider,
    // Pins and boot source
    output logic [GPIO_W-1:0]          gpio_pull_en,
    output logic [GPIO_W-1:0]          gpio_oe,
    output logic [1:0]                 boot_source,
    output logic                       flash_read_req,
    output logic [23:0]                flash_read_addr,
    output logic                       image_ready,
    // RAM write port
    output logic                       ram_we,
    output logic [RAM_ADDR_W-1:0]      ram_addr,
    output logic [7:0]                 ram_wdata,
    // Status
    output logic                       run_start,
    output logic [RAM_ADDR_W-1:0]      run_pc,
    output logic                       boot_fail,
    output logic                       boot_done
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] x;
        x = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    function automatic logic [1:0] src_decode(input logic [1:0] m);
        unique case (m)
            2'h0: return SRC_CODE_00;
            2'h1: return SRC_CODE_01;
            2'h2: return SRC_CODE_10;
            2'h3: return SRC_CODE_11;
        endcase
    endfunction

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic [5:0] sync_nxt;

    always_comb begin
        sync_nxt = {clock_source_strap, freq_strap_1, freq_strap_0, boot_mode_strap,
                    security_word[SECURE_BOOT_BIT]};
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
        end else begin
            sync1_r <= sync_nxt;
            sync2_r <= sync1_r;
        end
    end

    logic       s_clk_src;
    logic [1:0] s_freq;
    logic [1:0] s_mode;
    logic       s_secure;
    assign s_clk_src = sync2_r[5];
    assign s_freq    = sync2_r[4:3];
    assign s_mode    = sync2_r[2:1];
    assign s_secure  = sync2_r[0];

    // ****************************************
    // Loader state
    // ****************************************
    load_state_t             state_r,    state_nxt;
    logic [HOLD_CNT_W-1:0]   hold_r,     hold_nxt;
    logic                    osc_r,      osc_nxt;
    logic [2:0]              odiv_r,     odiv_nxt;
    logic [11:0]             mul_r,      mul_nxt;
    logic [5:0]              idiv_r,     idiv_nxt;
    logic [GPIO_W-1:0]       pull_r,     pull_nxt;
    logic [1:0]              src_r,      src_nxt;
    logic                    fread_r,    fread_nxt;
    logic                    ready_r,    ready_nxt;
    logic [31:0]             word_r,     word_nxt;
    logic [1:0]              bcnt_r,     bcnt_nxt;
    logic [31:0]             size_r,     size_nxt;
    logic [31:0]             left_r,     left_nxt;
    logic [31:0]             crc_r,      crc_nxt;
    logic                    we_r,       we_nxt;
    logic [RAM_ADDR_W-1:0]   addr_r,     addr_nxt;
    logic [7:0]              wdata_r,    wdata_nxt;
    logic                    run_r,      run_nxt;
    logic                    fail_r,     fail_nxt;
    logic                    done_r,     done_nxt;
    logic [31:0]             shifted;

    always_comb begin
        state_nxt = state_r;
        hold_nxt  = hold_r;
        osc_nxt   = osc_r;
        odiv_nxt  = odiv_r;
        mul_nxt   = mul_r;
        idiv_nxt  = idiv_r;
        pull_nxt  = pull_r;
        src_nxt   = src_r;
        fread_nxt = 1'b0;
        ready_nxt = ready_r;
        word_nxt  = word_r;
        bcnt_nxt  = bcnt_r;
        size_nxt  = size_r;
        left_nxt  = left_r;
        crc_nxt   = crc_r;
        we_nxt    = 1'b0;
        addr_nxt  = addr_r;
        wdata_nxt = wdata_r;
        run_nxt   = 1'b0;
        fail_nxt  = fail_r;
        done_nxt  = done_r;
        // Bytes complete words low byte first.
        shifted   = {image_byte, word_r[31:8]};
        if (pll_cfg_write && state_r != ST_HOLD) begin
            odiv_nxt = pll_cfg_output_divider;
            mul_nxt  = pll_cfg_multiplier;
            idiv_nxt = pll_cfg_input_divider;
        end
        unique case (state_r)
            ST_HOLD: begin
                // Straps are sampled throughout the hold, so they settle before use.
                osc_nxt  = s_clk_src;
                idiv_nxt = PLL_IDIV_RESET;
                unique case (s_freq)
                    2'h0: begin odiv_nxt = PLL_OD_00; mul_nxt = PLL_MUL_00; end
                    2'h3: begin odiv_nxt = PLL_OD_11; mul_nxt = PLL_MUL_11; end
                    2'h2: begin odiv_nxt = PLL_OD_10; mul_nxt = PLL_MUL_10; end
                    2'h1: begin odiv_nxt = PLL_OD_01; mul_nxt = PLL_MUL_01; end
                endcase
                src_nxt = s_secure ? SRC_OTP : src_decode(s_mode);
                if (hold_r == HOLD_CNT_W'(HOLD_CLOCKS - 1)) begin
                    pull_nxt  = '1;
                    state_nxt = ST_SIZE;
                    ready_nxt = 1'b1;
                    crc_nxt   = CRC_PRESET;
                    bcnt_nxt  = 2'h0;
                    fread_nxt = (src_nxt == SRC_FLASH);
                end else begin
                    hold_nxt = hold_r + 1'b1;
                end
            end
            ST_SIZE: begin
                if (image_valid) begin
                    word_nxt = shifted;
                    bcnt_nxt = bcnt_r + 1'b1;
                    crc_nxt  = crc_byte(crc_r, image_byte);
                    if (bcnt_r == 2'h3) begin
                        size_nxt  = shifted;
                        left_nxt  = {shifted[29:0], 2'h0};
                        addr_nxt  = '0;
                        state_nxt = (shifted == 32'h00000000) ? ST_CHECK : ST_PROG;
                    end
                end
            end
            ST_PROG: begin
                if (image_valid) begin
                    we_nxt    = 1'b1;
                    wdata_nxt = image_byte;
                    if (size_r != 32'h00000000 && left_r != {size_r[29:0], 2'h0}) begin
                        addr_nxt = addr_r + 1'b1;
                    end
                    crc_nxt  = crc_byte(crc_r, image_byte);
                    left_nxt = left_r - 1'b1;
                    if (left_r == 32'h00000001) begin
                        state_nxt = ST_CHECK;
                        bcnt_nxt  = 2'h0;
                    end
                end
            end
            ST_CHECK: begin
                if (image_valid) begin
                    word_nxt = shifted;
                    bcnt_nxt = bcnt_r + 1'b1;
                    if (bcnt_r == 2'h3) begin
                        state_nxt = ST_VERIFY;
                        ready_nxt = 1'b0;
                    end
                end
            end
            ST_VERIFY: begin
                done_nxt = 1'b1;
                if (word_r == CRC_BYPASS_WORD || word_r == ~crc_r) begin
                    run_nxt   = 1'b1;
                    state_nxt = ST_RUN;
                end else begin
                    fail_nxt  = 1'b1;
                    state_nxt = ST_FAIL;
                end
            end
            ST_RUN: begin
            end
            ST_FAIL: begin
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_HOLD;
            hold_r  <= '0;
            osc_r   <= 1'b0;
            odiv_r  <= PLL_OD_00;
            mul_r   <= PLL_MUL_00;
            idiv_r  <= PLL_IDIV_RESET;
            pull_r  <= '0;
            src_r   <= SRC_NONE;
            fread_r <= 1'b0;
            ready_r <= 1'b0;
            word_r  <= 32'h00000000;
            bcnt_r  <= 2'h0;
            size_r  <= 32'h00000000;
            left_r  <= 32'h00000000;
            crc_r   <= CRC_PRESET;
            we_r    <= 1'b0;
            addr_r  <= '0;
            wdata_r <= 8'h00;
            run_r   <= 1'b0;
            fail_r  <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            hold_r  <= hold_nxt;
            osc_r   <= osc_nxt;
            odiv_r  <= odiv_nxt;
            mul_r   <= mul_nxt;
            idiv_r  <= idiv_nxt;
            pull_r  <= pull_nxt;
            src_r   <= src_nxt;
            fread_r <= fread_nxt;
            ready_r <= ready_nxt;
            word_r  <= word_nxt;
            bcnt_r  <= bcnt_nxt;
            size_r  <= size_nxt;
            left_r  <= left_nxt;
            crc_r   <= crc_nxt;
            we_r    <= we_nxt;
            addr_r  <= addr_nxt;
            wdata_r <= wdata_nxt;
            run_r   <= run_nxt;
            fail_r  <= fail_nxt;
            done_r  <= done_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // The PLL fields feed the analogue divider, which forms the tile clock from them.
    assign use_internal_osc   = osc_r;
    assign pll_output_divider = odiv_r;
    assign pll_multiplier     = mul_r;
    assign pll_input_divider  = idiv_r;
    assign gpio_pull_en       = pull_r;
    assign gpio_oe            = GPIO_W'(0);
    assign boot_source        = src_r;
    assign flash_read_req     = fread_r;
    assign flash_read_addr    = 24'h000000;
    assign image_ready        = ready_r;
    assign ram_we             = we_r;
    assign ram_addr           = addr_r;
    assign ram_wdata          = wdata_r;
    assign run_start          = run_r;
    assign run_pc             = '0;
    assign boot_fail          = fail_r;
    assign boot_done          = done_r;

endmodule
`default_nettype wire

// ### inc/boot_loader_pkg.sv
// Constants and types shared by the boot clock setup loader.
package boot_loader_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLOCK_MHZ         = 125;
    localparam int unsigned RESET_HOLD_CLOCKS = 750000;
    localparam int unsigned HOLD_CNT_W        = 20;

    // ****************************************
    // Reset PLL settings per frequency strap pair
    // ****************************************
    localparam logic [2:0]  PLL_OD_00  = 3'h1;
    localparam logic [11:0] PLL_MUL_00 = 12'h07A;
    localparam logic [2:0]  PLL_OD_11  = 3'h2;
    localparam logic [11:0] PLL_MUL_11 = 12'h077;
    localparam logic [2:0]  PLL_OD_10  = 3'h2;
    localparam logic [11:0] PLL_MUL_10 = 12'h031;
    localparam logic [2:0]  PLL_OD_01  = 3'h2;
    localparam logic [11:0] PLL_MUL_01 = 12'h017;
    localparam logic [5:0]  PLL_IDIV_RESET = 6'h00;

    // ****************************************
    // Boot image
    // ****************************************
    localparam logic [31:0] CRC_BYPASS_WORD = 32'h0D15AB1E;
    localparam logic [31:0] CRC_POLY        = 32'hEDB88320;
    localparam logic [31:0] CRC_PRESET      = 32'hFFFFFFFF;
    localparam int unsigned SECURE_BOOT_BIT = 5;
    localparam int unsigned GPIO_W          = 32;
    localparam int unsigned RAM_ADDR_W      = 16;

    // ****************************************
    // Boot source encoding and loader states
    // ****************************************
    typedef enum logic [1:0] {
        SRC_FLASH = 2'h0,
        SRC_LINK  = 2'h1,
        SRC_OTP   = 2'h2,
        SRC_NONE  = 2'h3
    } boot_src_t;

    typedef enum logic [2:0] {
        ST_HOLD,
        ST_SIZE,
        ST_PROG,
        ST_CHECK,
        ST_VERIFY,
        ST_RUN,
        ST_FAIL
    } load_state_t;

endpackage

// ### bench/boot_loader_chk.sv
// Checker of the boot clock setup loader port behaviour.
`timescale 1ns/10ps
`default_nettype none
module boot_loader_chk
    import boot_loader_pkg::*;
#(
    parameter int unsigned HOLD_CLOCKS = 20
) (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        clock_source_strap,
    input wire logic [31:0] security_word,
    input wire logic        pll_cfg_write,
    input wire logic [2:0]  pll_cfg_output_divider,
    input wire logic [11:0] pll_cfg_multiplier,
    input wire logic        use_internal_osc,
    input wire logic [2:0]  pll_output_divider,
    input wire logic [11:0] pll_multiplier,
    input wire logic [31:0] gpio_pull_en,
    input wire logic [31:0] gpio_oe,
    input wire logic [1:0]  boot_source,
    input wire logic        flash_read_req,
    input wire logic [23:0] flash_read_addr,
    input wire logic        image_ready,
    input wire logic        ram_we,
    input wire logic [15:0] ram_addr,
    input wire logic        run_start,
    input wire logic [15:0] run_pc,
    input wire logic        boot_fail,
    input wire logic        boot_done
);
    localparam logic [19:0] HOLD_W = HOLD_CLOCKS[19:0];
    logic [19:0] up_r, up_nxt;
    logic [15:0] wr_r, wr_nxt;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // The cycle count saturates so that a long run never wraps into the hold window.
    always_comb begin
        up_nxt = (up_r == 20'hFFFFF) ? up_r : up_r + 20'h1;
        wr_nxt = ram_we ? wr_r + 16'h1 : wr_r;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            up_r <= 20'h0;
            wr_r <= 16'h0;
        end else begin
            up_r <= up_nxt;
            wr_r <= wr_nxt;
        end
    end
    a_pins_undriven: assert property (disable iff (1'b0) gpio_oe == 32'h0)
        else $error("pins driven");
    a_hold_quiet: assert property ((up_r < HOLD_W) |-> !image_ready && gpio_pull_en == 32'h0)
        else $error("boot started inside hold");
    a_hold_length: assert property ($rose(image_ready) |-> up_r == HOLD_W && &gpio_pull_en)
        else $error("hold length or pulls wrong");
    a_flash_cmd: assert property (flash_read_req |->
        flash_read_addr == 24'h0 && boot_source == SRC_FLASH ##1 !flash_read_req)
        else $error("flash read request wrong");
    a_osc_copy: assert property (image_ready |-> use_internal_osc == clock_source_strap)
        else $error("oscillator choice wrong");
    a_otp_force: assert property (image_ready && security_word[SECURE_BOOT_BIT] |->
        boot_source == SRC_OTP)
        else $error("secure boot not forced");
    a_ram_order: assert property (ram_we |-> ram_addr == wr_r)
        else $error("ram address out of order");
    a_start_zero: assert property (run_start |->
        run_pc == 16'h0 && boot_done && !boot_fail ##1 !run_start)
        else $error("bad program start");
    a_fail_sticky: assert property (boot_fail |=> boot_fail && !run_start)
        else $error("failure not held");
    a_pll_load: assert property (pll_cfg_write && gpio_pull_en[0] |=>
        pll_multiplier == $past(pll_cfg_multiplier) &&
        pll_output_divider == $past(pll_cfg_output_divider))
        else $error("pll write not applied");
    a_done_closed: assert property (boot_done |-> !image_ready)
        else $error("stream open after load");
    c_start: cover property (run_start);
    c_fail: cover property ($rose(boot_fail));
    c_flash: cover property (flash_read_req);
    c_pll: cover property (pll_cfg_write && gpio_pull_en[0]);
endmodule
bind boot_clock_setup_loader boot_loader_chk #(.HOLD_CLOCKS(HOLD_CLOCKS)) u_chk (
    .clock(clock), .rstn(rstn), .clock_source_strap(clock_source_strap),
    .security_word(security_word), .pll_cfg_write(pll_cfg_write),
    .pll_cfg_output_divider(pll_cfg_output_divider), .pll_cfg_multiplier(pll_cfg_multiplier),
    .use_internal_osc(use_internal_osc), .pll_output_divider(pll_output_divider),
    .pll_multiplier(pll_multiplier), .gpio_pull_en(gpio_pull_en), .gpio_oe(gpio_oe),
    .boot_source(boot_source), .flash_read_req(flash_read_req),
    .flash_read_addr(flash_read_addr), .image_ready(image_ready), .ram_we(ram_we),
    .ram_addr(ram_addr), .run_start(run_start), .run_pc(run_pc), .boot_fail(boot_fail),
    .boot_done(boot_done));
`default_nettype wire

// ### bench/boot_source_model.sv
// Boot source model that streams queued image bytes.
`timescale 1ns/10ps
`default_nettype none
module boot_source_model (
    input  wire logic       clock,
    input  wire logic       image_ready,
    input  wire logic       slow,
    output logic            image_valid,
    output logic [7:0]      image_byte
);
    logic [7:0] byte_q[$];
    logic       gap = 1'b0;
    initial begin
        image_valid = 1'b0;
        image_byte  = 8'hA5;
    end
    // Idle data toggles so a stale byte can never be taken by mistake.
    always @(negedge clock) begin
        if (image_ready && byte_q.size() > 0 && !(slow && gap)) begin
            image_valid <= 1'b1;
            image_byte  <= byte_q.pop_front();
        end else begin
            image_valid <= 1'b0;
            image_byte  <= ~image_byte;
        end
        gap <= ~gap;
    end
endmodule
`default_nettype wire

// ### bench/boot_clock_setup_loader_tb_top.sv
// Testbench of the boot clock setup loader.
`timescale 1ns/10ps
`default_nettype none
module boot_clock_setup_loader_tb_top;
    import boot_loader_pkg::*;
    localparam int unsigned HOLD = 20;
    logic        clock, rstn, clock_source_strap, freq_strap_0, freq_strap_1, slow;
    logic        pll_cfg_write, image_valid, use_internal_osc, flash_read_req;
    logic        image_ready, ram_we, run_start, boot_fail, boot_done;
    logic [1:0]  boot_mode_strap, boot_source;
    logic [31:0] security_word, gpio_pull_en, gpio_oe;
    logic [2:0]  pll_cfg_output_divider, pll_output_divider;
    logic [11:0] pll_cfg_multiplier, pll_multiplier;
    logic [5:0]  pll_cfg_input_divider, pll_input_divider;
    logic [7:0]  image_byte, ram_wdata;
    logic [23:0] flash_read_addr;
    logic [15:0] ram_addr, run_pc;
    logic [7:0]  ram_img [0:255];
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          starts;
    int          freqs;
    boot_clock_setup_loader #(.HOLD_CLOCKS(HOLD)) i_boot_clock_setup_loader (
        .clock(clock), .rstn(rstn), .clock_source_strap(clock_source_strap),
        .freq_strap_0(freq_strap_0), .freq_strap_1(freq_strap_1),
        .boot_mode_strap(boot_mode_strap), .security_word(security_word),
        .pll_cfg_write(pll_cfg_write), .pll_cfg_output_divider(pll_cfg_output_divider),
        .pll_cfg_multiplier(pll_cfg_multiplier), .pll_cfg_input_divider(pll_cfg_input_divider),
        .image_valid(image_valid), .image_byte(image_byte), .use_internal_osc(use_internal_osc),
        .pll_output_divider(pll_output_divider), .pll_multiplier(pll_multiplier),
        .pll_input_divider(pll_input_divider), .gpio_pull_en(gpio_pull_en), .gpio_oe(gpio_oe),
        .boot_source(boot_source), .flash_read_req(flash_read_req),
        .flash_read_addr(flash_read_addr), .image_ready(image_ready), .ram_we(ram_we),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .run_start(run_start), .run_pc(run_pc),
        .boot_fail(boot_fail), .boot_done(boot_done));
    boot_source_model src (.clock(clock), .image_ready(image_ready), .slow(slow),
        .image_valid(image_valid), .image_byte(image_byte));
    always #4 clock = ~clock;
    // One process owns the capture state, so a reset clears it without a second writer.
    always @(posedge clock) begin
        if (!rstn) begin
            starts <= 0;
            freqs <= 0;
            foreach (ram_img[j]) ram_img[j] <= 8'hXX;
        end else begin
            if (ram_we) ram_img[ram_addr[7:0]] <= ram_wdata;
            if (run_start) starts <= starts + 1;
            if (flash_read_req) freqs <= freqs + 1;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_hi(input bit done);
        int i;
        for (i = 0; i < 300; i++) begin
            if ((done ? boot_done : image_ready) === 1'b1) break;
            @(negedge clock);
        end
        if (i == 300) begin
            error_cnt++;
            close_out();
        end
    endtask
    function automatic logic [31:0] crc_add(input logic [31:0] c, input logic [7:0] b);
        int k;
        c = c ^ {24'h0, b};
        for (k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        return c;
    endfunction
    function automatic logic [31:0] prog(input int i);
        return 32'h89ABCDEF ^ (i * 32'h01030507);
    endfunction
    task automatic push_word(input logic [31:0] w, inout logic [31:0] crc);
        int k;
        for (k = 0; k < 4; k++) begin
            src.byte_q.push_back(w[8*k +: 8]);
            crc = crc_add(crc, w[8*k +: 8]);
        end
    endtask
    // Kind 0 sends a good check word, 1 a wrong one, 2 the bypass word.
    task automatic boot(input logic [1:0] fs, input logic [1:0] mode, input logic sec,
                        input int s, input int kind);
        logic [31:0] crc, chk, src_exp;
        int i;
        @(negedge clock);
        rstn = 1'b0;
        {freq_strap_1, freq_strap_0} = fs;
        boot_mode_strap = mode;
        security_word = {26'h0, sec, 5'h0};
        clock_source_strap = fs[0];
        slow = fs[1];
        repeat (12) @(negedge clock);
        check(gpio_pull_en, 32'h0);
        check(gpio_oe, 32'h0);
        rstn = 1'b1;
        wait_hi(0);
        check(gpio_pull_en, 32'hFFFFFFFF);
        check({pll_output_divider, pll_input_divider, pll_multiplier},
              (fs == 2'b00) ? {3'h1, 6'h0, 12'h07A} : (fs == 2'b11) ? {3'h2, 6'h0, 12'h077} :
              (fs == 2'b10) ? {3'h2, 6'h0, 12'h031} : {3'h2, 6'h0, 12'h017});
        check(use_internal_osc, fs[0]);
        src_exp = sec ? 2 : (mode == 2'b00) ? 0 : (mode == 2'b01) ? 1 : 3;
        check(boot_source, src_exp);
        crc = 32'hFFFFFFFF;
        push_word(s, crc);
        for (i = 0; i < s; i++) push_word(prog(i), crc);
        chk = (kind == 2) ? 32'h0D15AB1E : (kind == 1) ? crc : ~crc;
        push_word(chk, crc);
        wait_hi(1);
        repeat (2) @(negedge clock);
        check(image_ready, 0);
        check(boot_fail, kind == 1);
        check(starts, kind != 1);
        check(freqs, mode == 2'b00 && !sec);
        check(run_pc, 0);
        for (i = 0; i < 4 * s; i++) begin
            check(ram_img[i], 8'(prog(i / 4) >> (8 * (i % 4))));
        end
        $display("boot test straps %b mode %b done", fs, mode);
    endtask
    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        {clock_source_strap, freq_strap_0, freq_strap_1, slow} = 4'h0;
        boot_mode_strap = 2'h0;
        security_word = 32'h0;
        pll_cfg_write = 1'b0;
        pll_cfg_output_divider = 3'h0;
        pll_cfg_multiplier = 12'h000;
        pll_cfg_input_divider = 6'h00;
        boot(2'b00, 2'b00, 1'b0, 2, 0);
        boot(2'b11, 2'b01, 1'b0, 3, 2);
        boot(2'b10, 2'b00, 1'b1, 1, 1);
        boot(2'b01, 2'b10, 1'b0, 0, 0);
        // Upper range limits are the awkward case for field widths.
        pll_cfg_output_divider = 3'h7;
        pll_cfg_multiplier = 12'hFFF;
        pll_cfg_input_divider = 6'h3F;
        pll_cfg_write = 1'b1;
        @(negedge clock);
        pll_cfg_write = 1'b0;
        check({pll_output_divider, pll_multiplier, pll_input_divider}, 21'h1FFFFF);
        $display("pll write test done");
        close_out();
    end
endmodule
`default_nettype wire
